// File: shared/bss_pkg.sv
// bss_pkg: constants shared by the soft-start / lock-protect motor logic.
// assumes a 100 MHz system clock; every interval counts 40 ns osc ticks.
package bss_pkg;

  // clock and internal oscillator
  localparam int CLK_NS  = 10;
  localparam int OSC_NS  = 40;
  localparam int OSC_DIV = OSC_NS / CLK_NS;

  // lock-protection intervals, as printed
  localparam int DET_SHORT_MS   = 500;
  localparam int DET_LONG_MS    = 1000;
  localparam int DET_LATCH_MS   = 2000;
  localparam int RETRY_SHORT_MS = 5000;
  localparam int RETRY_LONG_MS  = 10000;
  localparam int IMM_REL_US     = 70;
  localparam int TICKS_PER_MS   = 1000000 / OSC_NS;
  localparam int IMM_REL_TICKS  = IMM_REL_US * 1000 / OSC_NS;

  // duty scale: per mille
  localparam logic [9:0] DUTY_FULL = 10'h3e8;
  localparam logic [9:0] WIN_LAST  = 10'h3e7;

  // dc command law, millivolts in, per mille out
  localparam int DC_GAIN  = 97;
  localparam int DC_OFS   = 88000;
  localparam int DC_DIV   = 300;
  localparam logic [11:0] DC_MIN_MV = 12'h3e8;
  localparam logic [11:0] DC_MAX_MV = 12'hfa0;

  // apb register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD_MV = 8'h04;
  localparam logic [7:0] REG_SST    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // reset values and field positions
  localparam logic        CTRL_RST     = 1'b0;
  localparam logic [11:0] CMD_MV_RST   = 12'h000;
  localparam logic [15:0] SST_RST      = 16'h0100;
  localparam int          ST_DUTY_LSB  = 10;
  localparam int          ST_RAMP_LSB  = 20;

  // sync bank bit positions
  localparam int IN_HALL  = 0;
  localparam int IN_SPD   = 1;
  localparam int IN_DIR   = 2;
  localparam int IN_REL   = 3;
  localparam int IN_SFS   = 4;
  localparam int IN_SLEEP = 5;
  localparam int IN_UV    = 6;
  localparam int IN_OV    = 7;
  localparam int IN_OC    = 8;
  localparam int IN_TSD   = 9;
  localparam int IN_SSTIE = 10;
  localparam int IN_W     = 11;

  typedef enum logic [4:0] {
    ST_SLEEP = 5'b00001,
    ST_START = 5'b00010,
    ST_RUN   = 5'b00100,
    ST_STOP  = 5'b01000,
    ST_LOCK  = 5'b10000
  } bss_state_e;

  typedef enum logic [1:0] {
    LK_AUTO  = 2'b00,
    LK_LATCH = 2'b01,
    LK_IMM   = 2'b10
  } bss_lock_e;

endpackage

// File: src/bss_motor_ctrl.sv
// bss_motor_ctrl: soft-start, direction sequencing, lock and fault logic
// of a single-hall brushless driver, with an apb register slave.
// assumes analog comparators deliver level flags on asynchronous pins.
//
// Contract
// - soft-start duty grows with elapsed time over triangle and pwm periods
// - soft-start ends once the ramp reaches the commanded duty
// - dc command duty is 97/3 times volts minus 88/3 percent, 1-4 V
// - soft-start applies every time start-up mode is entered
// - ramp timing comes from the command against the soft-start triangle
// - soft-start pin tied to regulator skips the ramp entirely
// - lock detection stays active during soft-start
// - direction change brakes to a stop before driving the new way
// - auto mode: no hall edge 0.5 s or 1.0 s brakes, lock low
// - auto mode: lock clears itself after 5 s or 10 s and retries
// - auto and immediate: hall, command, direction, uv, sleep release lock
// - latch mode: no hall edge over 2.0 s brakes and latches lock low
// - latch mode: only undervoltage or sleep clears the lock
// - immediate mode: lock after 0.5 s, cleared after 70 us
// - undervoltage flag short-brakes until it clears
// - overvoltage flag short-brakes until it clears
// - overcurrent comparator short-brakes until it clears
// - thermal flag turns all outputs off until it clears
// - no speed pulses during start-up mode
// - lock release select chooses between the lock mode families
// - sleep turns drive and regulator off; low runs normally
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module bss_motor_ctrl #(
  parameter int DET_SHORT_TICKS   = bss_pkg::DET_SHORT_MS*bss_pkg::TICKS_PER_MS,
  parameter int DET_LONG_TICKS    = bss_pkg::DET_LONG_MS*bss_pkg::TICKS_PER_MS,
  parameter int DET_LATCH_TICKS   = bss_pkg::DET_LATCH_MS*bss_pkg::TICKS_PER_MS,
  parameter int RETRY_SHORT_TICKS = bss_pkg::RETRY_SHORT_MS*bss_pkg::TICKS_PER_MS,
  parameter int RETRY_LONG_TICKS  = bss_pkg::RETRY_LONG_MS*bss_pkg::TICKS_PER_MS
) (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic             PREADY_OUT,
  output logic [31:0]      PRDATA_OUT,
  output logic             PSLVERR_OUT,
  // asynchronous pins and flags
  input  wire logic        HALL_IN,
  input  wire logic        SPEED_COMMAND_IN,
  input  wire logic        DIRECTION_SELECT_IN,
  input  wire logic        LOCK_RELEASE_SELECT_IN,
  input  wire logic        START_FREQ_SELECT_IN,
  input  wire logic        SLEEP_IN,
  input  wire logic        UNDERVOLT_IN,
  input  wire logic        OVERVOLT_IN,
  input  wire logic        OVERCURRENT_IN,
  input  wire logic        THERMAL_IN,
  input  wire logic        SOFTSTART_CAP_TIED_IN,
  // bridge control
  output logic             DRIVE_PWM_OUT,
  output logic             DIRECTION_OUT,
  output logic             SHORT_BRAKE_OUT,
  output logic             ALL_OFF_OUT,
  output logic             LOCK_DETECT_N_OUT,
  output logic             SPEED_PULSE_OUT,
  output logic             REGULATOR_EN_OUT
);
  import bss_pkg::*;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  function automatic logic [9:0] dc_duty(input logic [11:0] mv);
    logic [11:0] c;
    logic [31:0] p;
    c = (mv < DC_MIN_MV) ? DC_MIN_MV : (mv > DC_MAX_MV) ? DC_MAX_MV : mv;
    p = (32'(DC_GAIN) * 32'(c) - 32'(DC_OFS)) / 32'(DC_DIV);
    return p[9:0];
  endfunction

  function automatic logic [27:0] t28(input int v);
    return v[27:0];
  endfunction

  // input synchronisers; bit order follows the IN_ positions
  logic [IN_W-1:0] pins_w;
  assign pins_w = {SOFTSTART_CAP_TIED_IN, THERMAL_IN, OVERCURRENT_IN,
                   OVERVOLT_IN, UNDERVOLT_IN, SLEEP_IN,
                   START_FREQ_SELECT_IN, LOCK_RELEASE_SELECT_IN,
                   DIRECTION_SELECT_IN, SPEED_COMMAND_IN, HALL_IN};
  logic [IN_W-1:0] sync1_q;
  logic [IN_W-1:0] sync2_q;
  logic [IN_W-1:0] prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_sync
      always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= pins_w[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi]  <= sync2_q[gi];
        end
      end
    end
  endgenerate

  logic hall_edge;
  logic uv_rise;
  logic sleep_s;
  logic bypass_s;
  assign hall_edge = sync2_q[IN_HALL] ^ prev_q[IN_HALL];
  assign uv_rise   = sync2_q[IN_UV] & ~prev_q[IN_UV];
  assign sleep_s   = sync2_q[IN_SLEEP];
  assign bypass_s  = sync2_q[IN_SSTIE];

  // 40 ns oscillator tick
  logic [1:0] div_q;
  logic       tick;
  assign tick = (div_q == 2'(OSC_DIV - 1));
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) div_q <= 2'h0;
    else             div_q <= tick ? 2'h0 : div_q + 2'h1;
  end

  // apb registers
  logic        dc_mode_q;
  logic [11:0] cmd_mv_q;
  logic [15:0] sst_per_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        acc;
  logic        mapped;
  logic [31:0] status_w;
  bss_state_e  state_q;
  bss_state_e  state_d;
  logic [9:0]  duty_eff;
  logic [9:0]  ramp_q;
  logic        lock_n_q;
  logic        brake_q;
  logic        alloff_q;
  logic        dir_q;

  assign acc    = PSEL_IN & PENABLE_IN & ~pready_q;
  assign mapped = PADDR_IN inside {REG_CTRL, REG_CMD_MV, REG_SST, REG_STATUS};
  assign status_w = {2'h0, ramp_q, duty_eff, 1'b0, dir_q, alloff_q,
                     brake_q, lock_n_q, state_q};

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      dc_mode_q <= CTRL_RST;
      cmd_mv_q  <= CMD_MV_RST;
      sst_per_q <= SST_RST;
    end else if (acc && PWRITE_IN) begin
      case (PADDR_IN)
        REG_CTRL:   dc_mode_q <= PWDATA_IN[0];
        REG_CMD_MV: cmd_mv_q  <= PWDATA_IN[11:0];
        REG_SST:    sst_per_q <= PWDATA_IN[15:0];
        default:    ;
      endcase
    end
  end

  // one wait state: ready comes from a flop
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & ~mapped;
      prdata_q  <= 32'h0;
      if (acc && !PWRITE_IN) begin
        case (PADDR_IN)
          REG_CTRL:   prdata_q <= {31'h0, dc_mode_q};
          REG_CMD_MV: prdata_q <= {20'h0, cmd_mv_q};
          REG_SST:    prdata_q <= {16'h0, sst_per_q};
          REG_STATUS: prdata_q <= status_w;
          default:    prdata_q <= 32'h0;
        endcase
      end
    end
  end

  // speed command: dc law or measured pwm duty over a 1000-tick window
  logic [9:0] win_q;
  logic [9:0] hi_q;
  logic [9:0] pwm_duty_q;
  logic [9:0] cmd_duty;
  logic       cmd_on_q;
  logic       cmd_event;
  assign cmd_duty  = dc_mode_q ? dc_duty(cmd_mv_q) : pwm_duty_q;
  assign cmd_event = (cmd_duty != 10'h0) & ~cmd_on_q;

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      win_q      <= 10'h0;
      hi_q       <= 10'h0;
      pwm_duty_q <= 10'h0;
      cmd_on_q   <= 1'b0;
    end else begin
      cmd_on_q <= (cmd_duty != 10'h0);
      if (tick) begin
        win_q <= (win_q == WIN_LAST) ? 10'h0 : win_q + 10'h1;
        if (win_q == WIN_LAST) begin
          pwm_duty_q <= hi_q + {9'h0, sync2_q[IN_SPD]};
          hi_q       <= 10'h0;
        end else begin
          hi_q <= hi_q + {9'h0, sync2_q[IN_SPD]};
        end
      end
    end
  end

  // soft-start ramp: one per mille per triangle cycle
  // the triangle period is software-set since the cap is off chip
  logic [15:0] sst_cnt_q;
  logic        ramp_done;
  assign ramp_done = bypass_s | (ramp_q >= cmd_duty);

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      sst_cnt_q <= 16'h0;
      ramp_q    <= 10'h0;
    end else if (state_q != ST_START) begin
      sst_cnt_q <= 16'h0;
      ramp_q    <= 10'h0;
    end else if (tick) begin
      if (sst_cnt_q + 16'h1 >= sst_per_q) begin
        sst_cnt_q <= 16'h0;
        if (ramp_q != DUTY_FULL) ramp_q <= ramp_q + 10'h1;
      end else begin
        sst_cnt_q <= sst_cnt_q + 16'h1;
      end
    end
  end

  always_comb begin
    duty_eff = cmd_duty;
    if (state_q == ST_START && !bypass_s && ramp_q < cmd_duty) begin
      duty_eff = ramp_q;
    end
  end

  // no-edge counter and lock timer, in oscillator ticks
  logic [27:0] nedge_q;
  logic [27:0] lock_cnt_q;
  bss_lock_e   lk_mode;
  logic [27:0] det_lim;
  logic [27:0] rel_lim;
  logic        dir_change;
  assign dir_change = sync2_q[IN_DIR] ^ dir_q;

  always_comb begin
    if (!sync2_q[IN_REL]) lk_mode = LK_AUTO;
    else if (!sync2_q[IN_SFS]) lk_mode = LK_LATCH;
    else lk_mode = LK_IMM;
    unique case (lk_mode)
      LK_AUTO: begin
        det_lim = sync2_q[IN_SFS] ? t28(DET_LONG_TICKS) : t28(DET_SHORT_TICKS);
        rel_lim = sync2_q[IN_SFS] ? t28(RETRY_LONG_TICKS)
                                  : t28(RETRY_SHORT_TICKS);
      end
      LK_LATCH: begin
        det_lim = t28(DET_LATCH_TICKS);
        rel_lim = 28'h0;
      end
      default: begin
        det_lim = t28(DET_SHORT_TICKS);
        rel_lim = t28(IMM_REL_TICKS);
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      nedge_q <= 28'h0;
    end else if (hall_edge || state_q != state_d) begin
      nedge_q <= 28'h0;
    end else if (tick && nedge_q != 28'hfffffff) begin
      nedge_q <= nedge_q + 28'h1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN)           lock_cnt_q <= 28'h0;
    else if (state_q != ST_LOCK) lock_cnt_q <= 28'h0;
    else if (tick)             lock_cnt_q <= lock_cnt_q + 28'h1;
  end

  // main sequence
  logic lock_hit;
  logic ev_release;
  assign lock_hit   = tick && (nedge_q + 28'h1 >= det_lim);
  assign ev_release = hall_edge | cmd_event | dir_change | uv_rise;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_SLEEP: if (!sleep_s) state_d = ST_START;
      ST_START: begin
        if (lock_hit) state_d = ST_LOCK;
        else if (dir_change) state_d = ST_STOP;
        else if (ramp_done) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (dir_change) state_d = ST_STOP;
        else if (lock_hit) state_d = ST_LOCK;
      end
      ST_STOP: if (lock_hit) state_d = ST_START;
      ST_LOCK: begin
        if (lk_mode == LK_LATCH) begin
          if (uv_rise) state_d = ST_START;
        end else if (ev_release) begin
          state_d = ST_START;
        end else if (tick && lock_cnt_q + 28'h1 >= rel_lim) begin
          state_d = ST_START;
        end
      end
      default: state_d = ST_SLEEP;
    endcase
    if (sleep_s) state_d = ST_SLEEP;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) state_q <= ST_SLEEP;
    else             state_q <= state_d;
  end

  // direction taken once the motor is at rest, or directly while in sleep
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) dir_q <= 1'b0;
    else if (state_q == ST_STOP && state_d == ST_START)
      dir_q <= sync2_q[IN_DIR];
    else if (state_q == ST_SLEEP) dir_q <= sync2_q[IN_DIR];
  end

  // output pwm carrier on the oscillator tick
  logic [9:0] pwm_cnt_q;
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) pwm_cnt_q <= 10'h0;
    else if (tick)   pwm_cnt_q <= (pwm_cnt_q == WIN_LAST) ? 10'h0
                                  : pwm_cnt_q + 10'h1;
  end

  // faults and bridge outputs
  logic brake_d;
  logic alloff_d;
  logic spd_q;
  logic reg_en_q;
  logic drive_q;
  assign alloff_d = sync2_q[IN_TSD] | sleep_s;
  assign brake_d  = ~alloff_d & (sync2_q[IN_UV] | sync2_q[IN_OV]
                    | sync2_q[IN_OC] | state_d == ST_LOCK
                    | state_d == ST_STOP);

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      brake_q  <= 1'b0;
      alloff_q <= 1'b1;
      lock_n_q <= 1'b1;
      drive_q  <= 1'b0;
      reg_en_q <= 1'b0;
    end else begin
      brake_q  <= brake_d;
      alloff_q <= alloff_d;
      lock_n_q <= (state_d != ST_LOCK);
      reg_en_q <= ~sleep_s;
      drive_q  <= ~brake_d & ~alloff_d & (pwm_cnt_q < duty_eff)
                  & (state_d == ST_START || state_d == ST_RUN);
    end
  end

  // speed pulse follows hall edges, silent in start-up
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) spd_q <= 1'b0;
    else if (hall_edge && state_q != ST_START) spd_q <= ~spd_q;
  end

  assign PREADY_OUT        = pready_q;
  assign PRDATA_OUT        = prdata_q;
  assign PSLVERR_OUT       = pslverr_q;
  assign DRIVE_PWM_OUT     = drive_q;
  assign DIRECTION_OUT     = dir_q;
  assign SHORT_BRAKE_OUT   = brake_q;
  assign ALL_OFF_OUT       = alloff_q;
  assign LOCK_DETECT_N_OUT = lock_n_q;
  assign SPEED_PULSE_OUT   = spd_q;
  assign REGULATOR_EN_OUT  = reg_en_q;

  AST_TSD_ALLOFF: assert property (sync2_q[IN_TSD] |=> ALL_OFF_OUT && !SHORT_BRAKE_OUT)
    else $error("thermal flag did not force all-off");
  AST_UV_BRAKE: assert property (sync2_q[IN_UV] && !alloff_d |=> SHORT_BRAKE_OUT)
    else $error("undervoltage did not brake");
  AST_OV_BRAKE: assert property (sync2_q[IN_OV] && !alloff_d |=> SHORT_BRAKE_OUT)
    else $error("overvoltage did not brake");
  AST_OC_BRAKE: assert property (sync2_q[IN_OC] && !alloff_d |=> SHORT_BRAKE_OUT)
    else $error("overcurrent did not brake");
  AST_NO_FG_START: assert property (state_q == ST_START |=> $stable(SPEED_PULSE_OUT))
    else $error("speed pulse moved during start-up");
  AST_LATCH_HOLD: assert property (state_q == ST_LOCK && lk_mode == LK_LATCH && !uv_rise && !sleep_s |=> state_q == ST_LOCK)
    else $error("latched lock released without uv or sleep");
  AST_DIR_STOP: assert property (state_q == ST_RUN && dir_change && !sleep_s |=> state_q == ST_STOP ##1 (SHORT_BRAKE_OUT || ALL_OFF_OUT))
    else $error("direction change did not stop first");
  AST_LOCK_PIN: assert property (state_q == ST_LOCK |-> !LOCK_DETECT_N_OUT)
    else $error("lock state without lock-detect low");
  AST_IMM_BOUND: assert property (state_q == ST_LOCK && lk_mode == LK_IMM |-> lock_cnt_q < t28(IMM_REL_TICKS))
    else $error("immediate lock held past release time");
  AST_SLEEP_REG: assert property (sleep_s |=> !REGULATOR_EN_OUT && !DRIVE_PWM_OUT)
    else $error("sleep left regulator or drive on");
  AST_BYPASS: assert property (state_q == ST_START && bypass_s |-> duty_eff == cmd_duty)
    else $error("bypass did not apply command duty");

  COV_LOCK: cover property (state_q == ST_RUN ##1 state_q == ST_LOCK);
  COV_RETRY: cover property (state_q == ST_LOCK ##1 state_q == ST_START);
  COV_REVERSE: cover property (state_q == ST_STOP ##1 state_q == ST_START);
  COV_RAMP: cover property (state_q == ST_START && !bypass_s ##1 state_q == ST_RUN);
endmodule

// File: tb/bss_motor_model.sv
// bss_motor_model: single-hall rotor that turns while the bridge drives it.
// assumes a braked, switched-off or stalled rotor gives no hall edges.
`timescale 1ns/1ns
module bss_motor_model #(
  parameter int HALF_CYC = 40
) (
  // clock
  input  wire logic clk_in,
  // bridge state and bench control
  input  wire logic brake_in,
  input  wire logic all_off_in,
  input  wire logic reg_en_in,
  input  wire logic stall_in,
  // hall comparator
  output logic      hall_out
);
  int   cnt_q  = 0;
  logic hall_q = 1'b0;

  // a stopped rotor leaves the magnet where it was, so the level holds
  always @(posedge clk_in) begin
    if (brake_in || all_off_in || !reg_en_in || stall_in) begin
      cnt_q <= 0;
    end else if (cnt_q == HALF_CYC - 1) begin
      cnt_q  <= 0;
      hall_q <= ~hall_q;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end

  assign hall_out = hall_q;
endmodule

// File: tb/tb.sv
// tb: self-checking bench for the soft-start and lock-protect logic.
// assumes the motor model spins the rotor whenever the bridge may drive.
`timescale 1ns/1ns
module tb;
  import bss_pkg::*;
  // short intervals, in 40 ns ticks; one tick is four clocks
  localparam int DS = 200;
  localparam int DL = 400;
  localparam int DT = 800;
  localparam int RS = 2000;
  localparam int RL = 4000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, hall;
  logic        spd = 1'b0, dir = 1'b0, rel = 1'b0, sfs = 1'b0, slp = 1'b0;
  logic        uv = 1'b0, ov = 1'b0, oc = 1'b0, tsd = 1'b0;
  logic        tied = 1'b1, stall = 1'b0;
  logic        pwm, dir_o, brake, off, lock_n, fg, reg_en, fg0;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  int          mv [3] = '{1000, 2500, 4000};

  initial begin
    forever #5 clk = ~clk;
  end

  bss_motor_ctrl #(.DET_SHORT_TICKS(DS), .DET_LONG_TICKS(DL),
    .DET_LATCH_TICKS(DT), .RETRY_SHORT_TICKS(RS),
    .RETRY_LONG_TICKS(RL)) dut_u (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
    .PSLVERR_OUT(pslverr), .HALL_IN(hall), .SPEED_COMMAND_IN(spd),
    .DIRECTION_SELECT_IN(dir), .LOCK_RELEASE_SELECT_IN(rel),
    .START_FREQ_SELECT_IN(sfs), .SLEEP_IN(slp), .UNDERVOLT_IN(uv),
    .OVERVOLT_IN(ov), .OVERCURRENT_IN(oc), .THERMAL_IN(tsd),
    .SOFTSTART_CAP_TIED_IN(tied), .DRIVE_PWM_OUT(pwm),
    .DIRECTION_OUT(dir_o), .SHORT_BRAKE_OUT(brake), .ALL_OFF_OUT(off),
    .LOCK_DETECT_N_OUT(lock_n), .SPEED_PULSE_OUT(fg),
    .REGULATOR_EN_OUT(reg_en));

  bss_motor_model motor_u (.clk_in(clk), .brake_in(brake),
    .all_off_in(off), .reg_en_in(reg_en), .stall_in(stall),
    .hall_out(hall));

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // run is about 45k cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // sel 0 watches lock-detect, sel 1 the applied direction
  task automatic wait_for(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? lock_n : dir_o) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, ((sel == 0) ? lock_n : dir_o)}, {31'h0, v});
  endtask

  initial begin
    idle(10);
    rst_n <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, REG_CMD_MV, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, REG_SST, 32'h0);
    check(rd, {16'h0, SST_RST});
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // dc command law with the ramp bypassed
    apb(1'b1, REG_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, REG_CMD_MV, 32'(mv[i]));
      idle(20);
      apb(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[19:10]), 32'((DC_GAIN * mv[i] - DC_OFS) / DC_DIV));
    end
    // ramp: one step per 4 ticks, so 16 clocks a step
    tied <= 1'b0;
    apb(1'b1, REG_SST, 32'h4);
    apb(1'b1, REG_CMD_MV, 32'(mv[1]));
    slp <= 1'b1;
    idle(10);
    check({30'h0, reg_en, pwm}, 32'h0);
    slp <= 1'b0;
    fg0 = fg;
    idle(1000);
    check({31'h0, fg}, {31'h0, fg0});
    apb(1'b0, REG_STATUS, 32'h0);
    check(32'(rd[29:20] >= 10'h037 && rd[29:20] <= 10'h042), 32'h1);
    idle(8000);
    apb(1'b0, REG_STATUS, 32'h0);
    check(32'(rd[19:10]), 32'h203);
    // reversal waits for the rotor to stop
    dir <= 1'b1;
    idle(20);
    check({31'h0, dir_o}, 32'h0);
    wait_for(1, 1'b1, 2000);
    // faults; thermal wins over the brake
    tsd <= 1'b1;
    uv  <= 1'b1;
    idle(10);
    check({30'h0, off, brake}, 32'h2);
    tsd <= 1'b0;
    idle(10);
    check({30'h0, off, brake}, 32'h1);
    uv <= 1'b0;
    idle(10);
    check({31'h0, brake}, 32'h0);
    ov <= 1'b1;
    idle(10);
    check({31'h0, brake}, 32'h1);
    ov <= 1'b0;
    oc <= 1'b1;
    idle(10);
    check({31'h0, brake}, 32'h1);
    oc <= 1'b0;
    idle(10);
    check({31'h0, brake}, 32'h0);
    // automatic reset mode, short intervals
    idle(100);
    stall <= 1'b1;
    idle(DS * 4 - 200);
    check({31'h0, lock_n}, 32'h1);
    wait_for(0, 1'b0, 400);
    check({31'h0, brake}, 32'h1);
    stall <= 1'b0;
    idle(RS * 4 - 400);
    check({31'h0, lock_n}, 32'h0);
    wait_for(0, 1'b1, 800);
    idle(100);
    stall <= 1'b1;
    wait_for(0, 1'b0, 1200);
    dir   <= 1'b0;
    stall <= 1'b0;
    wait_for(0, 1'b1, 20);
    wait_for(1, 1'b0, 2000);
    // long detection with the select high
    idle(100);
    sfs   <= 1'b1;
    stall <= 1'b1;
    idle(DL * 4 - 200);
    check({31'h0, lock_n}, 32'h1);
    wait_for(0, 1'b0, 400);
    slp <= 1'b1;
    wait_for(0, 1'b1, 20);
    slp   <= 1'b0;
    stall <= 1'b0;
    // latch mode: no self-release, direction ignored
    idle(200);
    rel   <= 1'b1;
    sfs   <= 1'b0;
    stall <= 1'b1;
    idle(DT * 4 - 200);
    check({31'h0, lock_n}, 32'h1);
    wait_for(0, 1'b0, 400);
    idle(RL * 2 + 1000);
    dir <= 1'b1;
    idle(20);
    check({31'h0, lock_n}, 32'h0);
    uv <= 1'b1;
    wait_for(0, 1'b1, 20);
    uv  <= 1'b0;
    sfs <= 1'b1;
    // immediate mode: rotor still stalled, lock then quick release
    wait_for(0, 1'b0, 2400);
    idle(IMM_REL_TICKS * 4 - 400);
    check({31'h0, lock_n}, 32'h0);
    wait_for(0, 1'b1, 800);
    test_done();
  end
endmodule
